// file: cmf_pkg.sv
// package: register map, field layout and constants for the filter block
package cmf_pkg;
   // ----------------------------------------
   // register byte addresses (apb, one word each)
   // ----------------------------------------
   localparam logic [7:0] CMF_OFF_MASK4 = 8'h00;
   localparam logic [7:0] CMF_OFF_MASK3 = 8'h04;
   localparam logic [7:0] CMF_OFF_MASK2 = 8'h08;
   localparam logic [7:0] CMF_OFF_MASK1 = 8'h0C;
   localparam logic [7:0] CMF_OFF_STML = 8'h10;
   localparam logic [7:0] CMF_OFF_STMH = 8'h14;
   localparam logic [7:0] CMF_OFF_MSG = 8'h18;
   localparam logic [7:0] CMF_OFF_PAGE = 8'h1C;
   localparam logic [7:0] CMF_OFF_TAG = 8'h20;
   localparam logic [7:0] CMF_OFF_CTRL = 8'h24;
   localparam logic [7:0] CMF_OFF_STAT = 8'h28;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CMF_STD_LSB = 21;
   localparam int CMF_EXT_LSB = 3;
   localparam int CMF_RTR_BIT = 2;
   localparam int CMF_IDE_BIT = 0;
   localparam int CMF_PAGE_AINC = 3;
   // ----------------------------------------
   // reset values and sizes
   // ----------------------------------------
   localparam logic [31:0] CMF_MASK_RST = 32'h0000_0000;
   localparam logic [31:0] CMF_TAG_RST = 32'h0000_0000;
   localparam logic [15:0] CMF_STAMP_RST = 16'h0000;
   localparam logic [2:0] CMF_IDX_RST = 3'h0;
   localparam int CMF_NBYTES = 8;
   // apb state machine, one-hot
   typedef enum logic [1:0] {
      CMF_IDLE = 2'b01,
      CMF_ACC = 2'b10
   } cmf_state_t;
endpackage

// file: cmf_filter.sv
// module: mask filter, time stamp and data window of one message object
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module cmf_filter
   import cmf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // received frame from the protocol engine (same clock)
   input wire logic rx_valid,
   input wire logic [28:0] rx_id,
   input wire logic rx_rtr,
   input wire logic rx_ide,
   input wire logic [15:0] rx_stamp,
   // hit pulse to the protocol engine
   output logic rx_hit
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   cmf_state_t st_reg, st_next;
   logic [31:0] mask_reg, mask_next; // four mask bytes as one word
   logic [31:0] tag_reg, tag_next; // identifier tag word
   logic [15:0] stamp_reg, stamp_next; // captured time stamp
   logic [7:0] data_reg [CMF_NBYTES]; // message object byte store
   logic [7:0] data_next [CMF_NBYTES];
   logic [2:0] idx_reg, idx_next; // data index
   logic ainc_reg, ainc_next; // auto-increment select
   logic rxen_reg, rxen_next; // object enabled for reception
   logic hit_reg, hit_next; // one-cycle hit pulse
   logic [31:0] rd_reg, rd_next; // registered read data
   logic rdy_reg, rdy_next; // registered pready
   logic err_reg, err_next; // registered pslverr
   logic acc; // access phase: write takes effect at its end; read data was taken at the setup edge
   logic match; // received frame agrees with tag on every enabled bit
   logic [7:0] win_byte; // byte under the data index, read path

   // address decode used by pslverr and the unmapped-address check
   function automatic logic cmf_known(input logic [7:0] a);
      case (a)
         CMF_OFF_MASK4, CMF_OFF_MASK3, CMF_OFF_MASK2, CMF_OFF_MASK1,
         CMF_OFF_STML, CMF_OFF_STMH, CMF_OFF_MSG, CMF_OFF_PAGE,
         CMF_OFF_TAG, CMF_OFF_CTRL, CMF_OFF_STAT: cmf_known = 1'b1;
         default: cmf_known = 1'b0;
      endcase
   endfunction

   // ----------------------------------------
   // acceptance compare
   // ----------------------------------------
   // ext frames compare 29 bits; std frames only 11 upper bits
   // bit 1 of mask and tag never takes part, so leftovers there are
   // harmless; std frames likewise ignore bits 20:3 of both words
   always_comb begin
      logic [31:0] rxw;
      logic [31:0] en;
      rxw = 32'h0000_0000;
      en = 32'h0000_0000;
      if (rx_ide) begin
         rxw[31:CMF_EXT_LSB] = rx_id;
         en[31:CMF_EXT_LSB] = mask_reg[31:CMF_EXT_LSB];
      end else begin
         rxw[31:CMF_STD_LSB] = rx_id[10:0];
         en[31:CMF_STD_LSB] = mask_reg[31:CMF_STD_LSB];
      end
      rxw[CMF_RTR_BIT] = rx_rtr;
      rxw[CMF_IDE_BIT] = rx_ide;
      en[CMF_RTR_BIT] = mask_reg[CMF_RTR_BIT];
      en[CMF_IDE_BIT] = mask_reg[CMF_IDE_BIT];
      match = (((rxw ^ tag_reg) & en) == 32'h0000_0000);
   end

   // access phase: the edge that ends it commits a write
   assign acc = (st_reg == CMF_ACC);

   // byte under the current index, shared by read mux and checks
   assign win_byte = data_reg[idx_reg];

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      logic [2:0] wsel;
      wsel = idx_reg; // a window write lands before the index steps
      st_next = st_reg;
      mask_next = mask_reg;
      tag_next = tag_reg;
      stamp_next = stamp_reg;
      data_next = data_reg;
      idx_next = idx_reg;
      ainc_next = ainc_reg;
      rxen_next = rxen_reg;
      hit_next = 1'b0;
      rd_next = rd_reg;
      rdy_next = 1'b0;
      err_next = 1'b0;
      // apb: no wait states, answer registered at the setup edge
      case (st_reg)
         CMF_IDLE: begin
            if (psel && !penable) begin
               st_next = CMF_ACC;
               rdy_next = 1'b1;
               err_next = !cmf_known(paddr);
               // read data is taken at the setup edge, so a read that
               // meets a reception sees the older stamp and tag
               rd_next = 32'h0000_0000;
               case (paddr)
                  CMF_OFF_MASK4: rd_next[7:0] = mask_reg[7:0];
                  CMF_OFF_MASK3: rd_next[7:0] = mask_reg[15:8];
                  CMF_OFF_MASK2: rd_next[7:0] = mask_reg[23:16];
                  CMF_OFF_MASK1: rd_next[7:0] = mask_reg[31:24];
                  CMF_OFF_STML: rd_next[7:0] = stamp_reg[7:0];
                  CMF_OFF_STMH: rd_next[7:0] = stamp_reg[15:8];
                  CMF_OFF_MSG: rd_next[7:0] = win_byte;
                  CMF_OFF_PAGE: rd_next[3:0] = {ainc_reg, idx_reg};
                  CMF_OFF_TAG: rd_next = tag_reg;
                  CMF_OFF_CTRL: rd_next[0] = rxen_reg;
                  default: rd_next = 32'h0000_0000;
               endcase
            end
         end
         CMF_ACC: begin
            st_next = CMF_IDLE;
            // write or read completes at this edge
            if (psel && penable && pwrite) begin
               case (paddr)
                  CMF_OFF_MASK4: mask_next[7:0] = pwdata[7:0];
                  CMF_OFF_MASK3: mask_next[15:8] = pwdata[7:0];
                  CMF_OFF_MASK2: mask_next[23:16] = pwdata[7:0];
                  CMF_OFF_MASK1: mask_next[31:24] = pwdata[7:0];
                  CMF_OFF_MSG: data_next[wsel] = pwdata[7:0];
                  CMF_OFF_PAGE: begin
                     idx_next = pwdata[2:0];
                     ainc_next = pwdata[CMF_PAGE_AINC];
                  end
                  CMF_OFF_TAG: tag_next = pwdata;
                  CMF_OFF_CTRL: rxen_next = pwdata[0];
                  default: ;
               endcase
            end
            // reads step the index as well as writes
            // wraps 7 -> 0 by 3-bit width
            if (psel && penable && paddr == CMF_OFF_MSG && ainc_reg) begin
               idx_next = idx_reg + 3'h1;
            end
         end
         default: st_next = CMF_IDLE;
      endcase
      // reception updates tag and stamp, never the mask; it wins over
      // a tag write in the same cycle, so the captured id is never
      // half overwritten by software
      if (rx_valid && rxen_reg && match) begin
         hit_next = 1'b1;
         tag_next = 32'h0000_0000;
         if (rx_ide) begin
            tag_next[31:CMF_EXT_LSB] = rx_id;
         end else begin
            tag_next[31:CMF_STD_LSB] = rx_id[10:0];
         end
         tag_next[CMF_RTR_BIT] = rx_rtr;
         stamp_next = rx_stamp;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // reset branch loads constants only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= CMF_IDLE;
         mask_reg <= CMF_MASK_RST;
         tag_reg <= CMF_TAG_RST;
         stamp_reg <= CMF_STAMP_RST;
         for (int i = 0; i < CMF_NBYTES; i++) begin
            data_reg[i] <= 8'h00;
         end
         idx_reg <= CMF_IDX_RST;
         ainc_reg <= 1'b0;
         rxen_reg <= 1'b0;
         hit_reg <= 1'b0;
         rd_reg <= 32'h0000_0000;
         rdy_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         mask_reg <= mask_next;
         tag_reg <= tag_next;
         stamp_reg <= stamp_next;
         data_reg <= data_next;
         idx_reg <= idx_next;
         ainc_reg <= ainc_next;
         rxen_reg <= rxen_next;
         hit_reg <= hit_next;
         rd_reg <= rd_next;
         rdy_reg <= rdy_next;
         err_reg <= err_next;
      end
   end

   // every output comes straight from a flip-flop
   assign prdata = rd_reg;
   assign pready = rdy_reg;
   assign pslverr = err_reg;
   assign rx_hit = hit_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // the mask moves only on a software write
   a_mask_no_rx: assert property ((!(psel && penable && pwrite)) |=>
      $stable(mask_reg)) else $error("mask changed without write");

   // hit pulse follows a match by one cycle, and only a match
   a_hit_on_match: assert property ((rx_valid && rxen_reg && match)
      |=> rx_hit) else $error("match not reported");
   a_no_hit_miss: assert property ((!(rx_valid && rxen_reg && match))
      |=> !rx_hit) else $error("spurious hit");

   // data index steps, wraps and reloads
   a_idx_wrap: assert property ((acc && psel && paddr == CMF_OFF_MSG
      && ainc_reg && idx_reg == 3'h7) |=> idx_reg == 3'h0)
      else $error("index did not wrap");
   a_idx_step: assert property ((acc && psel && paddr == CMF_OFF_MSG
      && ainc_reg) |=> idx_reg == $past(idx_reg) + 3'h1)
      else $error("index did not step");
   a_page_idx: assert property ((acc && psel && pwrite &&
      paddr == CMF_OFF_PAGE) |=> idx_reg == $past(pwdata[2:0]))
      else $error("page index not loaded");

   // mask bits decide what takes part in the compare; the stamp high byte reads back
   a_rtr_mask: assert property ((rx_valid && rxen_reg &&
      mask_reg[CMF_RTR_BIT] && rx_rtr != tag_reg[CMF_RTR_BIT]) |=> !rx_hit)
      else $error("rtr mask ignored");
   a_ide_mask: assert property ((rx_valid && rxen_reg &&
      mask_reg[CMF_IDE_BIT] && rx_ide != tag_reg[CMF_IDE_BIT]) |=> !rx_hit)
      else $error("format mask ignored");
   a_stamp_read: assert property ((psel && !penable && !acc &&
      paddr == CMF_OFF_STMH) |=> prdata == {24'h00_0000, $past(stamp_reg[15:8])})
      else $error("stamp high byte wrong");
   a_std_mask: assert property ((rx_valid && rxen_reg && !rx_ide &&
      mask_reg[31:CMF_STD_LSB] == 11'h000 && !mask_reg[CMF_RTR_BIT] &&
      !mask_reg[CMF_IDE_BIT]) |=> rx_hit) else $error("open mask missed");
   // the answer stands for exactly one cycle
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready held");
   // no wait states: the answer follows every setup edge
   a_ready_setup: assert property ((psel && !penable && !acc) |=>
      pready) else $error("pready missing after setup");
   // unmapped offsets are refused with an error response
   a_bad_addr: assert property ((psel && !penable && !acc &&
      !cmf_known(paddr)) |=> pslverr) else $error("unmapped not refused");

   // the window shows the byte under the index of the setup edge
   a_msg_read: assert property ((psel && !penable && !acc &&
      paddr == CMF_OFF_MSG) |=> prdata == {24'h00_0000, $past(win_byte)})
      else $error("window byte wrong");

   // a hit captures identifier and stamp; a miss leaves the stamp
   a_tag_capture: assert property ((rx_valid && rxen_reg && match &&
      rx_ide) |=> tag_reg[31:CMF_EXT_LSB] == $past(rx_id))
      else $error("tag not captured");
   a_stamp_take: assert property ((rx_valid && rxen_reg &&
      match) |=> stamp_reg == $past(rx_stamp))
      else $error("stamp not captured");
   a_stamp_hold: assert property ((!(rx_valid && rxen_reg &&
      match)) |=> $stable(stamp_reg)) else $error("stamp moved on miss");

   // main scenarios the bench should reach
   c_hit: cover property (rx_valid && rxen_reg && match);
   c_wrap: cover property (acc && paddr == CMF_OFF_MSG && idx_reg == 3'h7);
   c_page: cover property (acc && pwrite && paddr == CMF_OFF_PAGE);
   c_bad: cover property (pslverr);
   c_ext_hit: cover property (rx_valid && rxen_reg && match && rx_ide);
endmodule
`default_nettype wire

// file: cmf_node_model.sv
// far-side model: other can nodes whose frames reach the filter
`timescale 1ns/10ps
`default_nettype none
module cmf_node_model (
   // clock
   input wire logic clk,
   // received frame toward the filter
   output logic rx_valid,
   output logic [28:0] rx_id,
   output logic rx_rtr,
   output logic rx_ide,
   output logic [15:0] rx_stamp
);
   // ----------------------------------------
   // idle bus and frame delivery
   // ----------------------------------------
   // quiet bus at time zero, no frame pending
   initial begin
      rx_valid = 1'b0;
      rx_id = '0;
      rx_rtr = 1'b0;
      rx_ide = 1'b0;
      rx_stamp = '0;
   end
   // one frame: fields are live only in the cycle that rx_valid is high
   task automatic send(input logic [28:0] id, input logic rtr,
      input logic identifier_format_bit, input logic [15:0] stamp);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_rtr <= rtr;
      rx_ide <= identifier_format_bit;
      rx_stamp <= stamp;
      @(posedge clk);
      rx_valid <= 1'b0;
      // inverted leftovers, so a late sample cannot pass for live data
      rx_id <= ~id;
      rx_rtr <= ~rtr;
      rx_ide <= ~identifier_format_bit;
      rx_stamp <= ~stamp;
   endtask
endmodule
`default_nettype wire

// file: can_mob_filter_timestamp_data_test.sv
// testbench: apb register access, filter cases and data window walk
`timescale 1ns/10ps
`default_nettype none
module can_mob_filter_timestamp_data_test;
   import cmf_pkg::*;
   // ----------------------------------------
   // signals and filter case table
   // ----------------------------------------
   typedef struct {
      logic [31:0] m;
      logic [31:0] t;
      logic [28:0] id;
      logic rtr;
      logic identifier_format_bit;
      logic hit;
   } cmf_case_t;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, rx_hit;
   logic rx_valid, rx_rtr, rx_ide;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, exp;
   logic [28:0] rx_id;
   logic [15:0] rx_stamp, st;
   logic err;
   cmf_case_t cs [10];
   int errors = 0;
   int n_compared = 0;
   cmf_filter dut_u (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr),
      .rx_ide(rx_ide), .rx_stamp(rx_stamp), .rx_hit(rx_hit));
   cmf_node_model node_u (.clk(clk), .rx_valid(rx_valid), .rx_id(rx_id),
      .rx_rtr(rx_rtr), .rx_ide(rx_ide), .rx_stamp(rx_stamp));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      n_compared++;
      if (got !== want) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   // apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // wait as long as it takes; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] want);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, want);
   endtask
   // mask lives in four byte registers, lowest byte at the lowest offset
   task automatic mask_io(input logic wr, input logic [31:0] m);
      for (int b = 0; b < 4; b++) begin
         apb(wr, CMF_OFF_MASK4 + 8'(4 * b), 32'(m[8 * b +: 8]));
         if (!wr) chk(rd, 32'(m[8 * b +: 8]));
      end
   endtask
   task automatic final_report;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // whole run needs well under a millisecond of simulated time
   initial begin
      #2_000_000;
      errors++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end
   initial begin
      // std cases keep bits 20:3 and 1 zero, ext cases keep bit 1 zero
      // last case: an all-open mask lets any std frame through
      cs = '{
      '{32'hFFFF_FFFD, 32'h091A_2B39, 29'h123_4567, 1'b0, 1'b1, 1'b1},
      '{32'hFFFF_FFFD, 32'h091A_2B39, 29'h123_4566, 1'b0, 1'b1, 1'b0},
      '{32'hFFFF_FFF5, 32'h091A_2B39, 29'h123_4566, 1'b0, 1'b1, 1'b1},
      '{32'hFFFF_FFFD, 32'h091A_2B39, 29'h123_4567, 1'b1, 1'b1, 1'b0},
      '{32'hFFFF_FFF9, 32'h091A_2B39, 29'h123_4567, 1'b1, 1'b1, 1'b1},
      '{32'hFFE0_0005, 32'hB460_0001, 29'h000_05A3, 1'b0, 1'b0, 1'b0},
      '{32'hFFE0_0004, 32'hB460_0001, 29'h000_05A3, 1'b0, 1'b0, 1'b1},
      '{32'hFFE0_0005, 32'hB460_0000, 29'h000_05A2, 1'b0, 1'b0, 1'b0},
      '{32'hFFC0_0005, 32'hB460_0000, 29'h000_05A2, 1'b0, 1'b0, 1'b1},
      '{32'h0000_0000, 32'h0000_0000, 29'h000_07FF, 1'b1, 1'b0, 1'b1}};
      {psel, penable, pwrite, paddr, pwdata} = '0;
      nrst = 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      // every register reads zero after reset, unmapped place refuses
      for (int a = 0; a <= 8'h28; a += 4) rdc(8'(a), 32'h0000_0000);
      rdc(8'h40, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      apb(1'b1, CMF_OFF_STML, 32'h0000_00FF);
      rdc(CMF_OFF_STML, 32'h0000_0000);
      // filter cases with receive enabled
      apb(1'b1, CMF_OFF_CTRL, 32'h0000_0001);
      for (int i = 0; i < 10; i++) begin
         st = {8'(i) ^ 8'hA5, 8'(i) ^ 8'h3C};
         mask_io(1'b1, cs[i].m);
         apb(1'b1, CMF_OFF_TAG, cs[i].t);
         node_u.send(cs[i].id, cs[i].rtr, cs[i].identifier_format_bit, st);
         #1;
         chk(32'(rx_hit), 32'(cs[i].hit));
         mask_io(1'b0, cs[i].m);
         if (cs[i].hit) begin
            exp = cs[i].identifier_format_bit ? {cs[i].id, cs[i].rtr, 2'b00} :
               {cs[i].id[10:0], 18'h0_0000, cs[i].rtr, 2'b00};
            apb(1'b0, CMF_OFF_TAG, 32'h0000_0000);
            chk(rd & (cs[i].identifier_format_bit ? 32'hFFFF_FFFC : 32'hFFE0_0004), exp);
            rdc(CMF_OFF_STML, 32'(st[7:0]));
            rdc(CMF_OFF_STMH, 32'(st[15:8]));
         end
      end
      // receive disabled: a frame that would pass is refused
      apb(1'b1, CMF_OFF_CTRL, 32'h0000_0000);
      rdc(CMF_OFF_CTRL, 32'h0000_0000);
      node_u.send(29'h000_07FF, 1'b1, 1'b0, ~st);
      #1;
      chk(32'(rx_hit), 32'h0000_0000);
      rdc(CMF_OFF_STML, 32'(st[7:0]));
      rdc(CMF_OFF_STMH, 32'(st[15:8]));
      // data window: fill with auto-increment, then read past the end
      apb(1'b1, CMF_OFF_PAGE, 32'h0000_0008);
      for (int i = 0; i < 8; i++) apb(1'b1, CMF_OFF_MSG, 32'(8'h10 + i));
      rdc(CMF_OFF_PAGE, 32'h0000_0008);
      for (int i = 0; i < 9; i++) rdc(CMF_OFF_MSG, 32'(8'h10 + i % 8));
      // fixed index without auto-increment stays put
      apb(1'b1, CMF_OFF_PAGE, 32'h0000_0005);
      rdc(CMF_OFF_MSG, 32'h0000_0015);
      rdc(CMF_OFF_MSG, 32'h0000_0015);
      rdc(CMF_OFF_PAGE, 32'h0000_0005);
      final_report();
   end
endmodule
`default_nettype wire
